// *** rtcm_regs.svh ***
// Constants of the two-wire host controller for the clock/calendar part
`ifndef RTCM_REGS_SVH
`define RTCM_REGS_SVH
// Notes on behaviour
// - One data bit moves per serial clock pulse.
// - Data line stays steady while clock is high; changes there are conditions.
// - Start: data falls while clock stays high.
// - Stop: data rises while clock stays high.
// - Idle bus leaves both lines released and high.
// - Master opens a transfer only when the bus is idle.
// - Each byte is eight bits plus one acknowledge clock.
// - No logical cap on data bytes between start and stop.
// - Master receiver acknowledges every read byte except the last.
// - Acknowledger holds data low through the whole acknowledge high phase.
// - Master ends a read by not acknowledging the last byte.
// - First byte after every start is the slave address.

// Slave addresses
`define RTCM_ADDR_WR 8'hA2
`define RTCM_ADDR_RD 8'hA3
// Bit index of the acknowledge slot within a byte
`define RTCM_ACK_BIT 4'h8
// Serial clock timing, 400 kHz bus on a 200 MHz system clock
`define RTCM_SCL_PERIOD_NS 2500
`define RTCM_CLK_PERIOD_NS 5
`define RTCM_QTR_CYC ((`RTCM_SCL_PERIOD_NS / 4) / `RTCM_CLK_PERIOD_NS)
`endif

// *** rtcm_pkg.sv ***
// Types of the two-wire host controller
package rtcm_pkg;
	// Sequencer states, Gray steps along idle-start-shift-load-stop
	typedef enum logic [2:0] {
		RTCM_IDLE = 3'h0,
		RTCM_STRT = 3'h1,
		RTCM_SHFT = 3'h3,
		RTCM_LOAD = 3'h2,
		RTCM_STOP = 3'h6
	} rtcm_state_t;

	// Which byte of the frame is on the wire
	typedef enum logic [1:0] {
		RTCM_SG_ADDRW = 2'h0,
		RTCM_SG_WADDR = 2'h1,
		RTCM_SG_ADDRR = 2'h3,
		RTCM_SG_DATA  = 2'h2
	} rtcm_stage_t;

	// Command: direction, register index, byte count minus one
	typedef struct packed {
		logic       rd;
		logic [3:0] waddr;
		logic [7:0] len;
	} rtcm_cmd_t;

	// Read byte with end-of-burst marker
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} rtcm_rd_t;

	// Filtered bus line levels
	typedef struct packed {
		logic scl;
		logic sda;
	} rtcm_line_t;

	// Line monitor state
	typedef struct packed {
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
		rtcm_line_t filt;
		logic       busy;
	} rtcm_mon_t;

	// Controller state
	typedef struct packed {
		rtcm_state_t st;
		rtcm_stage_t stage;
		logic [1:0]  phase;
		logic [15:0] qcnt;
		logic [3:0]  bitn;
		logic [7:0]  shreg;
		logic        rd;
		logic [3:0]  waddr;
		logic [7:0]  remain;
		logic        scl_o;
		logic        scl_oe;
		logic        sda_o;
		logic        sda_oe;
		logic        cmd_ready;
		logic        wr_ready;
		logic        rd_valid;
		rtcm_rd_t    rd_out;
		logic        done;
		logic        err;
	} rtcm_ctl_t;
endpackage

// *** rtcm_line_mon.sv ***
// Pin synchroniser and bus busy tracker for the two-wire lines
`include "rtcm_regs.svh"
module rtcm_line_mon (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output rtcm_pkg::rtcm_line_t line_q,
	output logic               bus_busy
);
	rtcm_pkg::rtcm_mon_t r_reg;
	rtcm_pkg::rtcm_mon_t r_next;

	// ***************************************************
	// Filtering and condition detection
	// ***************************************************
	// A level counts only once stages two and three agree
	always_comb begin
		r_next = r_reg;
		r_next.scl_sh = {r_reg.scl_sh[1:0], scl_i};
		r_next.sda_sh = {r_reg.sda_sh[1:0], sda_i};
		if (r_reg.scl_sh[2] == r_reg.scl_sh[1]) begin
			r_next.filt.scl = r_reg.scl_sh[2];
		end
		if (r_reg.sda_sh[2] == r_reg.sda_sh[1]) begin
			r_next.filt.sda = r_reg.sda_sh[2];
		end
		// Start falls data under high clock, stop raises it
		if (r_reg.filt.scl && r_next.filt.scl && r_reg.filt.sda && !r_next.filt.sda) begin
			r_next.busy = 1'b1;
		end else if (r_reg.filt.scl && r_next.filt.scl && !r_reg.filt.sda && r_next.filt.sda) begin
			r_next.busy = 1'b0;
		end
	end

	// State register; lines assumed high after reset
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			r_reg <= '{scl_sh: 3'h7, sda_sh: 3'h7, filt: 2'h3, busy: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign line_q   = r_reg.filt;
	assign bus_busy = r_reg.busy;

	a_start_busy: assert property (@(posedge clock) disable iff (!rst_b)
		($fell(r_reg.filt.sda) && r_reg.filt.scl && $past(r_reg.filt.scl)) |-> r_reg.busy)
		else $error("start not marked busy");
endmodule

// *** rtcm_host.sv ***
// Two-wire bus master that reads and writes the clock/calendar slave
`include "rtcm_regs.svh"
module rtcm_host #(
	parameter int QTR_CYC = `RTCM_QTR_CYC
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             cmd_valid,
	output logic                  cmd_ready,
	input  wire rtcm_pkg::rtcm_cmd_t cmd,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [7:0]       wr_data,
	output logic                  rd_valid,
	output rtcm_pkg::rtcm_rd_t    rd_out,
	output logic                  done,
	output logic                  err,
	input  wire logic             scl_i,
	output logic                  scl_o,
	output logic                  scl_oe,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe
);
	rtcm_pkg::rtcm_ctl_t  r_reg;
	rtcm_pkg::rtcm_ctl_t  r_next;
	rtcm_pkg::rtcm_line_t line_q;
	logic                 bus_busy;
	logic                 qdone;
	logic                 enter0;
	logic                 ack;

	// ***************************************************
	// Helpers
	// ***************************************************
	// Are we the transmitter for the current byte
	function automatic logic is_tx(input rtcm_pkg::rtcm_ctl_t s);
		is_tx = (s.stage != rtcm_pkg::RTCM_SG_DATA) || !s.rd;
	endfunction

	// Data line pull-down wanted during the low half of a bit
	function automatic logic sda_low(input rtcm_pkg::rtcm_ctl_t s);
		sda_low = 1'b0;
		unique case (s.st)
			rtcm_pkg::RTCM_SHFT: begin
				if (s.bitn < `RTCM_ACK_BIT) begin
					sda_low = is_tx(s) && !s.shreg[7];
				end else begin
					sda_low = !is_tx(s) && (s.remain != 8'h00);
				end
			end
			rtcm_pkg::RTCM_STOP: sda_low = 1'b1;
			rtcm_pkg::RTCM_IDLE,
			rtcm_pkg::RTCM_STRT,
			rtcm_pkg::RTCM_LOAD: sda_low = 1'b0;
		endcase
	endfunction

	// ***************************************************
	// Line monitor
	// ***************************************************
	rtcm_line_mon u_mon (
		.clock    (clock),
		.rst_b    (rst_b),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.line_q   (line_q),
		.bus_busy (bus_busy)
	);

	// Quarter-bit timer end
	assign qdone = (r_reg.qcnt == 16'(QTR_CYC - 1));
	// Slave pulled data low in the acknowledge slot
	assign ack = !line_q.sda;

	// ***************************************************
	// Sequencer
	// ***************************************************
	// Each bit is four quarters: two with clock low, two with it released
	always_comb begin
		r_next = r_reg;
		enter0 = 1'b0;
		r_next.done = 1'b0;
		r_next.rd_valid = 1'b0;
		r_next.qcnt = qdone ? 16'h0000 : r_reg.qcnt + 16'h0001;
		unique case (r_reg.st)
			rtcm_pkg::RTCM_IDLE: begin
				r_next.qcnt = 16'h0000;
				if (cmd_valid && r_reg.cmd_ready) begin
					r_next.rd = cmd.rd;
					r_next.waddr = cmd.waddr;
					r_next.remain = cmd.len;
					r_next.err = 1'b0;
					r_next.stage = rtcm_pkg::RTCM_SG_ADDRW;
					r_next.shreg = `RTCM_ADDR_WR;
					r_next.st = rtcm_pkg::RTCM_STRT;
					r_next.phase = 2'h0;
					enter0 = 1'b1;
				end
			end
			rtcm_pkg::RTCM_LOAD: begin
				// Clock held low while the source has no byte ready
				r_next.qcnt = 16'h0000;
				if (wr_valid && r_reg.wr_ready) begin
					r_next.shreg = wr_data;
					r_next.bitn = 4'h0;
					r_next.st = rtcm_pkg::RTCM_SHFT;
					r_next.phase = 2'h0;
					enter0 = 1'b1;
				end
			end
			rtcm_pkg::RTCM_STRT,
			rtcm_pkg::RTCM_STOP,
			rtcm_pkg::RTCM_SHFT: begin
				if (qdone && r_reg.phase == 2'h2 && !line_q.scl) begin
					r_next.phase = 2'h2; // Clock held low by someone else: wait
				end else if (qdone && r_reg.phase != 2'h3) begin
					r_next.phase = r_reg.phase + 2'h1;
					if (r_reg.phase == 2'h1) begin
						r_next.scl_oe = 1'b0;
					end
					if (r_reg.phase == 2'h2 && r_reg.st == rtcm_pkg::RTCM_STRT) begin
						r_next.sda_oe = 1'b1;
					end
					if (r_reg.phase == 2'h2 && r_reg.st == rtcm_pkg::RTCM_STOP) begin
						r_next.sda_oe = 1'b0;
					end
				end else if (qdone) begin
					r_next.phase = 2'h0;
					enter0 = 1'b1;
					if (r_reg.st == rtcm_pkg::RTCM_STRT) begin
						r_next.st = rtcm_pkg::RTCM_SHFT;
						r_next.bitn = 4'h0;
					end else if (r_reg.st == rtcm_pkg::RTCM_STOP) begin
						r_next.st = rtcm_pkg::RTCM_IDLE;
						r_next.done = 1'b1;
						enter0 = 1'b0;
					end else if (r_reg.bitn < `RTCM_ACK_BIT) begin
						// Sample at the end of the high half, data is settled
						r_next.shreg = {r_reg.shreg[6:0], is_tx(r_reg) ? 1'b0 : line_q.sda};
						r_next.bitn = r_reg.bitn + 4'h1;
					end else begin
						r_next.bitn = 4'h0;
						unique case (r_reg.stage)
							rtcm_pkg::RTCM_SG_ADDRW: begin
								r_next.stage = rtcm_pkg::RTCM_SG_WADDR;
								r_next.shreg = {4'h0, r_reg.waddr};
							end
							rtcm_pkg::RTCM_SG_WADDR: begin
								if (r_reg.rd) begin
									// Repeated start turns the bus round for reading
									r_next.stage = rtcm_pkg::RTCM_SG_ADDRR;
									r_next.shreg = `RTCM_ADDR_RD;
									r_next.st = rtcm_pkg::RTCM_STRT;
								end else begin
									r_next.stage = rtcm_pkg::RTCM_SG_DATA;
									r_next.st = rtcm_pkg::RTCM_LOAD;
								end
							end
							rtcm_pkg::RTCM_SG_ADDRR: begin
								r_next.stage = rtcm_pkg::RTCM_SG_DATA;
								r_next.shreg = 8'h00;
							end
							rtcm_pkg::RTCM_SG_DATA: begin
								if (r_reg.rd) begin
									r_next.rd_valid = 1'b1;
									r_next.rd_out = '{data: r_reg.shreg, last: r_reg.remain == 8'h00};
								end
								// One address, many bytes: slave steps its own pointer
								if (r_reg.remain == 8'h00) begin
									r_next.st = rtcm_pkg::RTCM_STOP;
								end else begin
									r_next.remain = r_reg.remain - 8'h01;
									r_next.st = r_reg.rd ? rtcm_pkg::RTCM_SHFT : rtcm_pkg::RTCM_LOAD;
								end
							end
						endcase
						// Any byte we sent without acknowledge ends the frame
						if (is_tx(r_reg) && !ack) begin
							r_next.err = 1'b1;
							r_next.st = rtcm_pkg::RTCM_STOP;
						end
					end
				end
			end
			default: begin
				r_next.st = rtcm_pkg::RTCM_IDLE;
			end
		endcase
		// Low half of a bit: pull the clock and present the data in the same cycle
		if (enter0) begin
			r_next.scl_oe = 1'b1;
			r_next.sda_oe = sda_low(r_next);
		end
		r_next.cmd_ready = (r_next.st == rtcm_pkg::RTCM_IDLE) && !bus_busy && !r_next.cmd_ready;
		r_next.wr_ready = (r_next.st == rtcm_pkg::RTCM_LOAD) && !(wr_valid && r_reg.wr_ready);
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ***************************************************
	// Outputs, all registered
	// ***************************************************
	assign cmd_ready = r_reg.cmd_ready;
	assign wr_ready  = r_reg.wr_ready;
	assign rd_valid  = r_reg.rd_valid;
	assign rd_out    = r_reg.rd_out;
	assign done      = r_reg.done;
	assign err       = r_reg.err;
	assign scl_o     = r_reg.scl_o;
	assign scl_oe    = r_reg.scl_oe;
	assign sda_o     = r_reg.sda_o;
	assign sda_oe    = r_reg.sda_oe;

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	a_bit_step: assert property ((r_reg.st == rtcm_pkg::RTCM_SHFT && r_reg.phase == 2'h3 && qdone
		&& r_reg.bitn < `RTCM_ACK_BIT) |=> r_reg.bitn == $past(r_reg.bitn) + 4'h1)
		else $error("bit counter did not advance");
	a_byte_len: assert property (r_reg.bitn <= `RTCM_ACK_BIT)
		else $error("byte longer than nine clocks");
	a_sda_steady: assert property ((r_reg.st == rtcm_pkg::RTCM_SHFT && !r_reg.scl_oe) |=>
		(r_reg.st != rtcm_pkg::RTCM_SHFT || r_reg.scl_oe || $stable(r_reg.sda_oe)))
		else $error("data moved while clock high");
	a_start_shape: assert property (($rose(r_reg.sda_oe) && !r_reg.scl_oe) |->
		$past(r_reg.st) == rtcm_pkg::RTCM_STRT)
		else $error("stray data fall under high clock");
	a_stop_shape: assert property (($fell(r_reg.sda_oe) && !r_reg.scl_oe) |->
		$past(r_reg.st) == rtcm_pkg::RTCM_STOP)
		else $error("stray data rise under high clock");
	a_idle_free: assert property (r_reg.st == rtcm_pkg::RTCM_IDLE |-> !r_reg.scl_oe && !r_reg.sda_oe)
		else $error("lines driven while idle");
	a_cmd_free: assert property ((cmd_valid && cmd_ready) |-> $past(!bus_busy) ##1
		r_reg.st == rtcm_pkg::RTCM_STRT)
		else $error("command taken on busy bus");
	a_addr_lead: assert property (($past(r_reg.st) == rtcm_pkg::RTCM_STRT && r_reg.st == rtcm_pkg::RTCM_SHFT)
		|-> (r_reg.shreg == `RTCM_ADDR_WR || r_reg.shreg == `RTCM_ADDR_RD))
		else $error("first byte after start is not an address");
	a_word_high: assert property ((r_reg.st == rtcm_pkg::RTCM_SHFT && r_reg.stage == rtcm_pkg::RTCM_SG_WADDR
		&& r_reg.bitn == 4'h0 && r_reg.phase == 2'h0) |-> r_reg.shreg[7:4] == 4'h0)
		else $error("word address upper nibble set");
	a_read_ack: assert property ((r_reg.st == rtcm_pkg::RTCM_SHFT && r_reg.rd && r_reg.stage == rtcm_pkg::RTCM_SG_DATA
		&& r_reg.bitn == `RTCM_ACK_BIT && r_reg.phase[1]) |-> r_reg.sda_oe == (r_reg.remain != 8'h00))
		else $error("read acknowledge wrong");

	c_write_ok: cover property (done && !err && !r_reg.rd);
	c_read_ok: cover property (rd_valid && rd_out.last ##[1:1000] done);
	c_nack: cover property (done && err);
	c_restart: cover property ($past(r_reg.st) == rtcm_pkg::RTCM_SHFT && r_reg.st == rtcm_pkg::RTCM_STRT);
endmodule

// *** rtcm_slave_model.sv ***
// Behavioural clock/calendar slave that answers the two-wire host in the bench
module rtcm_slave_model #(
	parameter real WDT_NS = 1.0E9
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic dev_off,
	output logic      sda_oe,
	output logic      frozen,
	output int        viol
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Slave state; the clock line is only ever read here
	// ************************************************************
	logic [7:0] mem [16];
	logic [7:0] sh    = 8'h00;
	logic [3:0] ptr   = 4'h0;
	logic [3:0] bitc  = 4'h0;
	logic       on    = 1'b0;
	logic       first = 1'b0;
	logic       sel   = 1'b0;
	logic       wadr  = 1'b0;
	logic       tx    = 1'b0;
	logic       go_tx = 1'b0;
	logic       mack  = 1'b0;
	realtime    t_addr = 0;
	int         lost  = 0;

	// Outputs start released
	initial begin
		sda_oe = 1'b0;
		frozen = 1'b0;
		viol = 0;
	end

	// Start and stop; looked at 1 ns late so a clock fall in the same step is not one
	always @(sda) begin
		#1;
		if (scl === 1'b1) begin
			if (on && bitc > 4'h1)
				viol = viol + 1;          // Data moved in a high phase mid-byte
			on = !sda && !dev_off;        // Start opens, stop closes
			bitc = 4'h0;
			first = 1'b1;                 // Address byte comes first
			tx = 1'b0;
			go_tx = 1'b0;
			sda_oe = 1'b0;                // Idle bus left released
			if (sda)
				frozen = 1'b0;            // Counting resumes at stop
		end
	end

	// Sampling in the high phase: eight bits then the acknowledge slot
	always @(posedge scl) if (on) begin
		if (bitc < 4'h8) begin
			if (!tx)
				sh = {sh[6:0], sda};      // One bit per pulse, MSB first
			bitc = bitc + 4'h1;
		end else begin
			mack = !sda;                  // Master answer on read bytes
			bitc = 4'h9;
		end
	end

	// Driving in the low phase, so data never moves while the clock is high
	always @(negedge scl) if (on) begin
		if (bitc == 4'h8 && !tx) begin
			if (first) begin
				sel = (sh[7:1] == 7'h51); // A2h write, A3h read, others ignored
				go_tx = sel && sh[0];
				wadr = sel && !sh[0];
				first = 1'b0;
				if (sel) begin
					frozen = 1'b1;        // Counters held during access
					t_addr = $realtime;
				end
			end else if (wadr) begin
				ptr = sh[3:0];            // Low nibble only
				wadr = 1'b0;
			end else if (sel) begin
				mem[ptr] = sh;
				ptr = ptr + 4'h1;         // No byte limit, pointer steps
			end
			sda_oe = sel;                 // Acknowledge every byte when selected
		end else if (bitc == 4'h8)
			sda_oe = 1'b0;                // Line freed for the master's answer
		else if (bitc == 4'h9) begin
			bitc = 4'h0;
			tx = go_tx || (tx && mack);   // Missing ack ends sending
			go_tx = 1'b0;
			sda_oe = 1'b0;
			if (tx) begin
				sh = mem[ptr];
				ptr = ptr + 4'h1;
				sda_oe = !sh[7];
			end
		end else if (tx && bitc != 4'h0)
			sda_oe = !sh[4'h7 - bitc];
	end

	// Watchdog; polling every 1 us keeps it inside the 1 s to 2 s band
	always begin
		#1000;
		if (frozen && ($realtime - t_addr) > WDT_NS) begin
			on = 1'b0;
			frozen = 1'b0;
			sda_oe = 1'b0;
			lost = lost + 1;
		end
	end
endmodule

// *** rtcm_host_bench.sv ***
// Self-checking bench of the two-wire host against the behavioural slave
module rtcm_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic       rd;
		logic [3:0] waddr;
		logic [7:0] len;
		logic [7:0] base;
	} rtcm_row_t;
	// ************************************************************
	// Signals and the wired-AND lines
	// ************************************************************
	logic                clock;
	logic                rst_b;
	logic                cmd_valid;
	logic                cmd_ready;
	rtcm_pkg::rtcm_cmd_t cmd;
	logic                wr_valid;
	logic                wr_ready;
	logic [7:0]          wr_data;
	logic                rd_valid;
	rtcm_pkg::rtcm_rd_t  rd_out;
	logic                done;
	logic                err;
	logic                scl_oe;
	logic                sda_oe;
	logic                scl_out;
	logic                sda_out;
	logic                dev_sda_oe;
	logic                dev_off;
	logic                frozen;
	int                  viol;
	logic                scl;
	logic                sda;
	int                  failures;
	int                  checks_done;
	logic [7:0]          exp_mem [16];
	rtcm_pkg::rtcm_rd_t  rdq [$];
	rtcm_row_t           rows [5] = '{'{0, 4'h3, 8'h02, 8'h40}, '{1, 4'h3, 8'h02, 8'h00},
		'{0, 4'hF, 8'h01, 8'h50}, '{1, 4'hF, 8'h01, 8'h00}, '{1, 4'h4, 8'h00, 8'h00}};

	// Pull-ups: a line is low while any party pulls it
	assign scl = !scl_oe;
	assign sda = !(sda_oe || dev_sda_oe);

	rtcm_host #(.QTR_CYC(4)) rtcm_host_inst (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_out(rd_out), .done(done), .err(err), .scl_i(scl), .scl_o(scl_out),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_out), .sda_oe(sda_oe));
	rtcm_slave_model rtcm_slave_model_inst (.scl(scl), .sda(sda), .dev_off(dev_off), .sda_oe(dev_sda_oe),
		.frozen(frozen), .viol(viol));

	// Clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Read bytes are one-cycle pulses, caught mid-cycle
	always @(negedge clock) if (rd_valid === 1'b1) rdq.push_back(rd_out);

	// ************************************************************
	// Compare, wait and command tasks
	// ************************************************************
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bounded wait; a hang counts as a mismatch and ends the run
	task automatic wait_high(ref logic s, input string what);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(negedge clock);
			if (s === 1'b1)
				return;
		end
		failures++;
		$display("CHECK FAILED %s expected 1 seen timeout", what);
		final_report();
	endtask

	task automatic issue(input rtcm_row_t r);
		@(posedge clock);
		cmd <= '{rd: r.rd, waddr: r.waddr, len: r.len};
		cmd_valid <= 1'b1;
		wait_high(cmd_ready, "cmd_ready");
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask

	// Whole command; writes stall a little each byte to see the clock held low
	task automatic run_cmd(input rtcm_row_t r, input logic exp_err);
		int k;
		rdq.delete();
		issue(r);
		for (k = 0; !r.rd && !exp_err && k <= r.len; k++) begin
			wait_high(wr_ready, "wr_ready");
			repeat (6) @(negedge clock);
			chk_bit("clock held in stall", 1'b0, scl);
			@(posedge clock);
			wr_valid <= 1'b1;
			wr_data <= r.base + 8'(k);
			@(posedge clock);
			wr_valid <= 1'b0;
			exp_mem[r.waddr + 4'(k)] = r.base + 8'(k);
		end
		wait_high(done, "done");
		chk_bit("err", exp_err, err);
		if (r.rd && !exp_err) begin
			chk_byte("read count", r.len + 8'h1, 8'(rdq.size()));
			for (k = 0; k < rdq.size(); k++) begin
				chk_byte("read data", exp_mem[r.waddr + 4'(k)], rdq[k].data);
				chk_bit("last mark", k == r.len, rdq[k].last);
			end
		end
		repeat (8) @(negedge clock);
		chk_bit("clock line idle", 1'b1, scl);
		chk_bit("data line idle", 1'b1, sda);
		chk_bit("counting resumed", 1'b0, frozen);
		chk_byte("misplaced conditions", 8'h00, 8'(viol));
		chk_bit("clock drive level", 1'b0, scl_out);
		chk_bit("data drive level", 1'b0, sda_out);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		dev_off = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		foreach (rows[i]) run_cmd(rows[i], 1'b0);
		// Absent slave: the address goes unanswered
		dev_off <= 1'b1;
		run_cmd('{1'b1, 4'h2, 8'h00, 8'h00}, 1'b1);
		// Reset in mid-frame releases both lines and silences every output
		issue(rows[0]);
		repeat (40) @(posedge clock);
		rst_b <= 1'b0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		chk_bit("clock pull in reset", 1'b0, scl_oe);
		chk_bit("data pull in reset", 1'b0, sda_oe);
		chk_bit("ready in reset", 1'b0, cmd_ready);
		chk_bit("done in reset", 1'b0, done);
		dev_off <= 1'b0;
		run_cmd(rows[1], 1'b0);
		final_report();
	end
endmodule
